// ### core/sfscu_device.sv
// flash device end: instruction front-end and status/protection register
//
// Behaviour
// - opcode 06h sets write latch flag
// - opcode 04h clears write latch flag
// - latch clears at power-up and cycle end
// - program/erase/status write need latch set
// - status read shifts byte, MSB first, falling
// - status byte repeats until select rises
// - status read accepted even while busy
// - status write is opcode plus one byte
// - only bits 7,5,4,3,2 written
// - status write needs exact byte boundary
// - busy high during self-timed write cycle
// - lock bit with guard low blocks status writes
// - protected regions reject program and erase
// - bytes travel MSB first on output line
// - ABh, three dummies, then repeating identifier
// - instruction starts at select fall, rising sample
// - busy ignores all but status read
// - write latch is status bit 1
// - reserved status bit 6 reads 0
`timescale 1ns/1ps
module sfscu_device
    import sfscu_pkg::*;
#(
    parameter int TW_CYC = SFSCU_TW_CYC,
    parameter int PGM_CYC = SFSCU_PGM_CYC,
    parameter int ADDR_BITS = 19
)(
    input wire logic mclk,
    input wire logic reset_n,
    sfscu_if.device link,
    output logic [7:0] status_view,
    output logic cycle_busy
);
    // sync stages; only stage 2 feeds logic
    typedef struct packed {
        logic [2:0] cs_s1;
        logic [2:0] cs_s2;
        logic [1:0] guard_s;
        logic cs_d;
        logic clk_d;
        logic lock;
        logic tb;
        logic [2:0] guard;
        logic wlf;
        logic busy;
        logic [31:0] timer;
        logic [7:0] pend_sr;
        logic pend_is_sr;
        logic [7:0] shin;
        logic [2:0] bitn;
        logic [3:0] bytes;
        logic [7:0] opc;
        logic [7:0] wrbyte;
        logic [23:0] addr;
        logic frame_bad;
        logic [7:0] shout;
        logic out_en;
        logic dout;
    } sfscu_dev_t;

    sfscu_dev_t q;
    sfscu_dev_t next_q;
    logic cs_n;
    logic sck;
    logic din;
    logic rise;
    logic fall;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] sr_now;
    logic [7:0] byte_in;
    logic prot_hit;
    logic [2:0] top_bits;

    assign cs_n = q.cs_s2[0];
    assign sck = q.cs_s2[1];
    assign din = q.cs_s2[2];
    assign rise = !cs_n && sck && !q.clk_d;
    assign fall = !cs_n && !sck && q.clk_d;
    assign cs_rise = cs_n && !q.cs_d;
    assign cs_fall = !cs_n && q.cs_d;
    assign byte_in = {q.shin[6:0], din};
    // reserved bit fixed at zero latch at bit 1 busy at bit 0
    assign sr_now = {q.lock, 1'b0, q.tb, q.guard, q.wlf, q.busy};
    assign top_bits = q.addr[ADDR_BITS-1 -: 3];

    // region check in eighths of the array
    always_comb
    begin
        prot_hit = 1'b0;
        if (q.guard[2])
            prot_hit = 1'b1;
        else if (q.guard[1:0] != 2'b00)
        begin
            if (!q.tb)
                prot_hit = top_bits >= 3'(8 - (1 << (q.guard[1:0] - 2'd1)));
            else
                prot_hit = top_bits < 3'(1 << (q.guard[1:0] - 2'd1));
        end
        if (q.opc == SFSCU_OP_CE1 || q.opc == SFSCU_OP_CE2)
            prot_hit = q.guard != 3'b000;
    end

    always_comb
    begin
        next_q = q;
        next_q.cs_s1 = {link.dual_line_low, link.sclk, link.select_n};
        next_q.cs_s2 = q.cs_s1;
        next_q.guard_s = {q.guard_s[0], link.guard_n};
        next_q.cs_d = cs_n;
        next_q.clk_d = sck;
        if (q.busy)
        begin
            if (q.timer == 32'd0)
            begin
                next_q.busy = 1'b0;
                next_q.wlf = 1'b0;
                if (q.pend_is_sr)
                begin
                    next_q.lock = q.pend_sr[SFSCU_SB_LOCK];
                    next_q.tb = q.pend_sr[SFSCU_SB_TB];
                    next_q.guard = q.pend_sr[SFSCU_SB_BP2:SFSCU_SB_BP0];
                end
            end
            else
                next_q.timer = q.timer - 32'd1;
        end
        if (cs_fall)
        begin
            next_q.bitn = 3'd0;
            next_q.bytes = 4'd0;
            next_q.frame_bad = 1'b0;
            next_q.out_en = 1'b0;
        end
        if (rise)
        begin
            next_q.shin = byte_in;
            next_q.bitn = q.bitn + 3'd1;
            if (q.bitn == 3'd7)
            begin
                if (q.bytes != 4'hF)
                    next_q.bytes = q.bytes + 4'd1;
                if (q.bytes == 4'd0)
                    next_q.opc = byte_in;
                else if (q.bytes == 4'd1)
                    next_q.wrbyte = byte_in;
                if (q.bytes >= 4'd1 && q.bytes <= 4'd3)
                    next_q.addr = {q.addr[15:0], byte_in};
                if (q.bytes == 4'd0 && byte_in == SFSCU_OP_RDSR)
                begin
                    next_q.shout = sr_now;
                    next_q.out_en = 1'b1;
                end
                if (q.bytes == 4'd3 && q.opc == SFSCU_OP_RDID && !q.busy)
                begin
                    next_q.shout = SFSCU_DEV_ID;
                    next_q.out_en = 1'b1;
                end
            end
        end
        if (fall && q.out_en)
        begin
            next_q.dout = q.shout[7];
            if (q.bitn == 3'd7)
                // reload after the last bit keeps the byte repeating
                next_q.shout = (q.opc == SFSCU_OP_RDSR) ? sr_now : SFSCU_DEV_ID;
            else
                next_q.shout = {q.shout[6:0], 1'b0};
        end
        if (cs_rise)
        begin
            next_q.out_en = 1'b0;
            // byte boundary required; busy ignores all but status read
            if (!q.busy && q.bitn == 3'd0 && q.bytes != 4'd0)
            begin
                unique case (q.opc)
                    SFSCU_OP_WREN: if (q.bytes == 4'd1) next_q.wlf = 1'b1;
                    SFSCU_OP_WRDI: if (q.bytes == 4'd1) next_q.wlf = 1'b0;
                    SFSCU_OP_WRSR:
                        // two bytes exactly, latch set, lock not engaged
                        if (q.bytes == 4'd2 && q.wlf && !(q.lock && !q.guard_s[1]))
                        begin
                            next_q.busy = 1'b1;
                            next_q.timer = 32'(TW_CYC - 1);
                            next_q.pend_is_sr = 1'b1;
                            next_q.pend_sr = q.wrbyte & SFSCU_SR_WMASK;
                        end
                    SFSCU_OP_PP, SFSCU_OP_SE, SFSCU_OP_BE32, SFSCU_OP_BE64:
                        if (q.wlf && q.bytes >= 4'd4 && !prot_hit)
                        begin
                            next_q.busy = 1'b1;
                            next_q.timer = 32'(PGM_CYC - 1);
                            next_q.pend_is_sr = 1'b0;
                        end
                    SFSCU_OP_CE1, SFSCU_OP_CE2:
                        if (q.wlf && q.bytes == 4'd1 && !prot_hit)
                        begin
                            next_q.busy = 1'b1;
                            next_q.timer = 32'(PGM_CYC - 1);
                            next_q.pend_is_sr = 1'b0;
                        end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.cs_s1 <= 3'b011;
            q.cs_s2 <= 3'b011;
            q.guard_s <= 2'b11;
            q.cs_d <= 1'b1;
        end
        else
            q <= next_q;
    end

    assign link.dh_out = q.dout;
    assign link.dh_oe = q.out_en;
    assign status_view = {q.lock, 1'b0, q.tb, q.guard, q.wlf, q.busy};
    assign cycle_busy = q.busy;
endmodule

// ### core/sfscu_pkg.sv
// shared constants for the serial flash status command unit
package sfscu_pkg;
    localparam logic [7:0] SFSCU_OP_WREN = 8'h06;
    localparam logic [7:0] SFSCU_OP_WRDI = 8'h04;
    localparam logic [7:0] SFSCU_OP_RDSR = 8'h05;
    localparam logic [7:0] SFSCU_OP_WRSR = 8'h01;
    localparam logic [7:0] SFSCU_OP_PP = 8'h02;
    localparam logic [7:0] SFSCU_OP_SE = 8'h20;
    localparam logic [7:0] SFSCU_OP_BE32 = 8'h52;
    localparam logic [7:0] SFSCU_OP_BE64 = 8'hD8;
    localparam logic [7:0] SFSCU_OP_CE1 = 8'hC7;
    localparam logic [7:0] SFSCU_OP_CE2 = 8'h60;
    localparam logic [7:0] SFSCU_OP_RDID = 8'hAB;
    // status bit positions
    localparam int SFSCU_SB_BUSY = 0;
    localparam int SFSCU_SB_WLF = 1;
    localparam int SFSCU_SB_BP0 = 2;
    localparam int SFSCU_SB_BP1 = 3;
    localparam int SFSCU_SB_BP2 = 4;
    localparam int SFSCU_SB_TB = 5;
    localparam int SFSCU_SB_RSV = 6;
    localparam int SFSCU_SB_LOCK = 7;
    // writable status bits: 7,5,4,3,2
    localparam logic [7:0] SFSCU_SR_WMASK = 8'hBC;
    localparam logic [7:0] SFSCU_SR_RESET = 8'h00;
    localparam logic [7:0] SFSCU_DEV_ID = 8'h5A; // arbitrary value
    // self-timed write cycle, microseconds, and cycles at 10 MHz
    localparam int SFSCU_CLK_MHZ = 10;
    localparam int SFSCU_TW_US = 100;
    localparam int SFSCU_TW_CYC = SFSCU_TW_US * SFSCU_CLK_MHZ;
    localparam int SFSCU_PGM_CYC = SFSCU_TW_CYC;
    // host serial clock divider: half period in mclk cycles
    localparam int SFSCU_HALF_DIV = 4;
    // host register offsets (AXI4-Lite byte addresses)
    localparam logic [7:0] SFSCU_REG_CMD = 8'h00;
    localparam logic [7:0] SFSCU_REG_DATA = 8'h04;
    localparam logic [7:0] SFSCU_REG_STAT = 8'h08;
    localparam logic [7:0] SFSCU_REG_RDATA = 8'h0C;
    localparam logic [1:0] SFSCU_RESP_OKAY = 2'b00;
    localparam logic [1:0] SFSCU_RESP_SLVERR = 2'b10;
endpackage

// ### core/sfscu_if.sv
// serial link between host controller and flash device
`timescale 1ns/1ps
interface sfscu_if;
    logic select_n;
    logic sclk;
    logic dl_out;
    logic dl_oe;
    logic dh_out;
    logic dh_oe;
    logic guard_n;
    logic dual_line_low;
    logic dual_line_high;
    // weak pull-up models an idle floating line
    assign dual_line_low = dl_oe ? dl_out : 1'b1;
    assign dual_line_high = dh_oe ? dh_out : 1'b1;
    modport host (output select_n, sclk, dl_out, dl_oe, guard_n, input dual_line_high);
    modport device (input select_n, sclk, dual_line_low, guard_n, output dh_out, dh_oe,
        input dl_out, dl_oe);
endinterface

// ### core/sfscu_host.sv
// host end: AXI4-Lite slave that frames instructions on the serial link
`timescale 1ns/1ps
module sfscu_host
    import sfscu_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    sfscu_if.host link
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic [7:0] aw_a;
        logic w_got;
        logic [31:0] w_d;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] txbuf;
        logic [2:0] nbytes;
        logic guard_n;
        logic run;
        logic [5:0] bitcnt;
        logic [2:0] bytecnt;
        logic [3:0] div;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic [1:0] miso_s;
        logic [7:0] rx;
    } sfscu_host_t;

    sfscu_host_t q;
    sfscu_host_t next_q;

    always_comb
    begin
        next_q = q;
        next_q.miso_s = {q.miso_s[0], link.dual_line_high};
        // write channel: address and data in either order
        if (awvalid && q.awready)
        begin
            next_q.aw_got = 1'b1;
            next_q.aw_a = awaddr;
            next_q.awready = 1'b0;
        end
        if (wvalid && q.wready)
        begin
            next_q.w_got = 1'b1;
            next_q.w_d = wdata;
            next_q.wready = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid)
        begin
            next_q.bresp = SFSCU_RESP_OKAY;
            if (q.aw_a == SFSCU_REG_CMD)
            begin
                // a command written mid-frame is acknowledged but dropped
                if (!q.run)
                begin
                    // [31:29] byte count, [28] guard level
                    next_q.nbytes = q.w_d[31:29];
                    next_q.guard_n = q.w_d[28];
                    next_q.run = q.w_d[31:29] != 3'd0;
                    next_q.bytecnt = 3'd0;
                    next_q.bitcnt = 6'd0;
                    next_q.cs_n = q.w_d[31:29] == 3'd0;
                    next_q.mosi = q.txbuf[31];
                end
            end
            else if (q.aw_a == SFSCU_REG_DATA)
                next_q.txbuf = q.w_d;
            else
                next_q.bresp = SFSCU_RESP_SLVERR;
            next_q.bvalid = 1'b1;
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
        end
        if (q.bvalid && bready)
        begin
            next_q.bvalid = 1'b0;
            next_q.awready = 1'b1;
            next_q.wready = 1'b1;
        end
        if (arvalid && q.arready)
        begin
            next_q.arready = 1'b0;
            next_q.rvalid = 1'b1;
            next_q.rresp = SFSCU_RESP_OKAY;
            unique case (araddr)
                SFSCU_REG_STAT: next_q.rdata = {31'd0, q.run};
                SFSCU_REG_RDATA: next_q.rdata = {24'd0, q.rx};
                SFSCU_REG_DATA: next_q.rdata = q.txbuf;
                default:
                begin
                    next_q.rdata = 32'd0;
                    next_q.rresp = SFSCU_RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && rready)
        begin
            next_q.rvalid = 1'b0;
            next_q.arready = 1'b1;
        end
        // serial engine: data set while clock low, sampled on rise
        if (q.run)
        begin
            if (q.div == 4'(SFSCU_HALF_DIV - 1))
            begin
                next_q.div = 4'd0;
                next_q.sclk = !q.sclk;
                if (q.sclk)
                begin
                    // sampled late in the bit: the reply crosses two synchronisers first
                    next_q.rx = {q.rx[6:0], q.miso_s[1]};
                    next_q.txbuf = {q.txbuf[30:0], 1'b0};
                    next_q.mosi = q.txbuf[30];
                    next_q.bitcnt = q.bitcnt + 6'd1;
                    // select rises only on a byte boundary
                    if (q.bitcnt[2:0] == 3'd7 && q.bitcnt[5:3] + 3'd1 == q.nbytes)
                    begin
                        next_q.run = 1'b0;
                        next_q.cs_n = 1'b1;
                    end
                end
            end
            else
                next_q.div = q.div + 4'd1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
            q.cs_n <= 1'b1;
            q.guard_n <= 1'b1;
        end
        else
            q <= next_q;
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign link.select_n = q.cs_n;
    assign link.sclk = q.sclk;
    assign link.dl_out = q.mosi;
    assign link.dl_oe = 1'b1;
    assign link.guard_n = q.guard_n;
endmodule

// ### verification/sfscu_link_properties.sv
// link protocol checks between the host and device ends
`timescale 1ns/1ps
module sfscu_link_properties (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic select_n,
    input wire logic sclk,
    input wire logic dl_oe,
    input wire logic dh_out,
    input wire logic dh_oe,
    input wire logic guard_n
);
    logic [2:0] rise_cnt;
    logic sclk_q;
    // rising edges per frame, modulo one byte
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rise_cnt <= 3'h0;
            sclk_q <= 1'b0;
        end
        else
        begin
            sclk_q <= sclk;
            if (select_n)
                rise_cnt <= 3'h0;
            else if (sclk && !sclk_q)
                rise_cnt <= rise_cnt + 3'h1;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    property p_sclk_idle; select_n && $past(select_n) |-> !sclk; endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moved outside frame");
    property p_half; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
    a_half: assert property (p_half) else $error("sclk high time wrong");
    property p_byte_end; $rose(select_n) |-> rise_cnt == 3'h0 && !sclk; endproperty
    a_byte_end: assert property (p_byte_end) else $error("frame ended mid byte");
    property p_out_fall; dh_oe && $past(dh_oe) && $changed(dh_out) |-> !sclk; endproperty
    a_out_fall: assert property (p_out_fall) else $error("output moved while sclk high");
    property p_release; $rose(select_n) |-> ##[1:6] !dh_oe; endproperty
    a_release: assert property (p_release) else $error("output held after select");
    property p_quiet; select_n[*6] |-> !dh_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("output driven while idle");
    property p_drive; dl_oe; endproperty
    a_drive: assert property (p_drive) else $error("host line not driven");
    property p_guard; !select_n && !$past(select_n) |-> $stable(guard_n); endproperty
    a_guard: assert property (p_guard) else $error("guard moved in frame");
    property p_opcode; $fell(select_n) |-> !dh_oe[*8]; endproperty
    a_opcode: assert property (p_opcode) else $error("output during opcode");
endmodule

// ### verification/test_spi_flash_status_command_unit.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module test_spi_flash_status_command_unit;
    import sfscu_pkg::*;
    typedef struct packed {logic [7:0] mask; logic [7:0] val;} sfscu_note_t;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic note_rd = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cycle_busy;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic [7:0] status_view, rnd;
    int n_fail = 0;
    int n_tests = 0;
    sfscu_note_t notes[$];
    sfscu_note_t note;
    sfscu_if link();
    sfscu_host i_sfscu_host (.mclk(mclk), .reset_n(reset_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .link(link));
    // long self-timed cycle so a whole frame fits inside it
    sfscu_device #(.TW_CYC(600), .PGM_CYC(600)) i_sfscu_device (.mclk(mclk),
        .reset_n(reset_n), .link(link), .status_view(status_view), .cycle_busy(cycle_busy));
    sfscu_link_properties i_sfscu_link_properties (.mclk(mclk), .reset_n(reset_n),
        .select_n(link.select_n), .sclk(link.sclk), .dl_oe(link.dl_oe),
        .dh_out(link.dh_out), .dh_oe(link.dh_oe), .guard_n(link.guard_n));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic nt);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        note_rd <= nt;
        do
        begin
            @(posedge mclk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
        note_rd <= 1'b0;
    endtask
    // bytes leave from the top of the word; waits until the frame is over
    task automatic send(input logic [31:0] bytes, input logic [2:0] n, input logic gn);
        axi_wr(SFSCU_REG_DATA, bytes);
        axi_wr(SFSCU_REG_CMD, {n, gn, 28'h000_0000});
        do
            axi_rd(SFSCU_REG_STAT, rd, 1'b0);
        while (rd[0] !== 1'b0);
        // margin for the device's input synchroniser
        repeat (8) @(posedge mclk);
    endtask
    task automatic rdsr(input logic [2:0] n, input logic [7:0] m, input logic [7:0] e);
        send({SFSCU_OP_RDSR, 24'h00_0000}, n, 1'b1);
        notes.push_back('{m, e});
        axi_rd(SFSCU_REG_RDATA, rd, 1'b1);
    endtask
    task automatic wren();
        send({SFSCU_OP_WREN, 24'h00_0000}, 3'd1, 1'b1);
    endtask
    task automatic wait_busy();
        while (cycle_busy !== 1'b0)
            @(posedge mclk);
    endtask
    always @(posedge mclk)
    begin
        if (rvalid === 1'b1 && rready && note_rd && notes.size() > 0)
        begin
            note = notes.pop_front();
            check(rdata[7:0] & note.mask, note.val);
        end
    end
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        #(100 * 40000);
        n_fail++;
        finish_test();
    end
    initial
    begin
        rnd = 8'($urandom(20));
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        check(status_view, SFSCU_SR_RESET);
        rdsr(3'd2, 8'hff, 8'h00);
        $display("test reset done");
        wren();
        check(status_view, 8'h02);
        rdsr(3'd2, 8'hff, 8'h02);
        send({SFSCU_OP_WRDI, 24'h00_0000}, 3'd1, 1'b1);
        check(status_view, 8'h00);
        send(32'h01ff_0000, 3'd2, 1'b1);
        check(8'(cycle_busy), 8'h00);
        check(status_view, 8'h00);
        $display("test latch done");
        rnd = 8'($urandom()) & 8'h7f;
        wren();
        send({SFSCU_OP_WRSR, rnd, 16'h0000}, 3'd2, 1'b1);
        check(8'(cycle_busy), 8'h01);
        rdsr(3'd2, 8'h03, 8'h03);
        // set request while busy must be lost
        wren();
        wait_busy();
        check(status_view, rnd & SFSCU_SR_WMASK);
        $display("test status write done");
        wren();
        send(32'h01ff_0000, 3'd2, 1'b1);
        wait_busy();
        rdsr(3'd3, 8'hff, SFSCU_SR_WMASK);
        wren();
        send({SFSCU_OP_PP, 24'h00_0000}, 3'd4, 1'b1);
        check(8'(cycle_busy), 8'h00);
        send(32'h0100_0000, 3'd2, 1'b0);
        check(8'(cycle_busy), 8'h00);
        check(status_view & 8'hfd, SFSCU_SR_WMASK);
        wren();
        send(32'h0100_0000, 3'd2, 1'b1);
        wait_busy();
        check(status_view, 8'h00);
        $display("test protection done");
        wren();
        send(32'h01bc_0000, 3'd3, 1'b1);
        check(8'(cycle_busy), 8'h00);
        check(status_view & 8'hfd, 8'h00);
        wren();
        send({SFSCU_OP_CE1, 24'h00_0000}, 3'd1, 1'b1);
        check(8'(cycle_busy), 8'h01);
        wait_busy();
        check(status_view, 8'h00);
        // three dummies, then two answer bytes: the last one is the repeat
        send({SFSCU_OP_RDID, 24'h00_0000}, 3'd6, 1'b1);
        notes.push_back('{8'hff, SFSCU_DEV_ID});
        axi_rd(SFSCU_REG_RDATA, rd, 1'b1);
        $display("test length and erase done");
        axi_wr(SFSCU_REG_DATA, 32'h0000_0000);
        check(8'(rsp), 8'(SFSCU_RESP_OKAY));
        axi_wr(8'h10, 32'h0000_0000);
        check(8'(rsp), 8'(SFSCU_RESP_SLVERR));
        axi_rd(8'h10, rd, 1'b0);
        check(8'(rsp), 8'(SFSCU_RESP_SLVERR));
        $display("test register bus done");
        finish_test();
    end
endmodule
